// [src/pse_event_interrupt_regs.sv]
// Operation
// - Enable bit per summary source; 1 enables, bit 7 supply down to bit 0.
// - Power-good/power-on toggle flags in bits 7:4/3:0, cleared reading 0x03.
// - Class-done/detect-done flags in bits 7:4/3:0, cleared reading 0x05.
// - Load-removed/overcurrent flags; 0x06 plain read, 0x07 clears.
// - Startup register: class overcurrent bits 7:4, startup failed bits 3:0.
// - Startup register read at 0x08 keeps, 0x09 clears; reset loads zero.
// - Supply register layout thermal..logic lockout, cleared reading 0x0B.
// - Overvoltage comparator of either supply sets its over flag.
// - Undervoltage comparator of either supply sets its under flag.
// - Oscillator weak flag interrupts only when an AC disconnect enable set.
// - Over-temperature resets device; thermal flag set once running resumes.
// - Thermal flag also set on every lockout reset exit.
// - While either supply locked out, hold reset and force ports off.
// - Leave lockout when last supply rises, both above threshold.
// - Read-only port status: class bits 6:4, detect bits 2:0, 7,3 zero.
// - Detection codes 000 unknown through 111 negative DC source.
// - Summary bits OR their groups; low interrupt on any enabled bit.
// - Global enable at 0x17 bit 7 gates the interrupt output.
// - Writing 1 to 0x1A bit 7 clears all event registers.
// - Toggle flags set on any edge of power-good or power-on status.
`timescale 1ns/1ps
`include "pse_event_cfg.svh"

module pse_event_interrupt_regs #(
    parameter int PORTS = 4
) (
    // Clock, reset, enable
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      clkEn,
    // Register port from the serial interface
    input  wire logic [7:0]                regAddr,
    input  wire logic                      regWrite,
    input  wire logic                      regRead,
    input  wire logic [7:0]                regWrData,
    output logic [7:0]                     regRdData,
    // Port events and results
    input  wire logic [PORTS-1:0]          power_good,
    input  wire logic [PORTS-1:0]          power_on_status,
    input  wire logic [PORTS-1:0]          classDoneEvt,
    input  wire logic [PORTS-1:0]          detectDoneEvt,
    input  wire logic [PORTS-1:0]          loadRemovedEvt,
    input  wire logic [PORTS-1:0]          overcurrentEvt,
    input  wire logic [PORTS-1:0]          classOvercurrentEvt,
    input  wire logic [PORTS-1:0]          startupFailedEvt,
    input  wire logic [PORTS*3-1:0]        classResult,
    input  wire logic [PORTS*3-1:0]        detectResult,
    input  wire logic [PORTS-1:0]          resultLoad,
    input  wire logic [PORTS-1:0]          ac_disconnect_enable,
    // Supply monitors
    input  wire logic                      logicOverCmp,
    input  wire logic                      logicUnderCmp,
    input  wire logic                      negOverCmp,
    input  wire logic                      negUnderCmp,
    input  wire logic                      logicLockoutCmp,
    input  wire logic                      negLockoutCmp,
    input  wire logic                      oscWeakCmp,
    input  wire logic                      overTempCmp,
    // Outputs
    output logic                           intr_n,
    output logic                           portsForcedOff,
    output logic                           deviceInReset
);
    import pse_event_pkg::*;

    // ======================================================================
    // Reset and lockout
    life_state_t state_reg;
    logic        holdReset;
    logic        lockout;
    logic        resumed;
    logic        lastLogic_reg;
    logic        lockSeen_reg;
    assign lockout   = logicLockoutCmp | negLockoutCmp;
    assign holdReset = rst | lockout | overTempCmp;
    assign resumed   = (state_reg == lockoutHeld) && !holdReset;

    // The state only leaves the hold once every cause of it has gone.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= lockoutHeld;
        end else if (clkEn) begin
            case (state_reg)
                lockoutHeld: begin
                    if (!lockout && !overTempCmp) begin
                        state_reg <= running;
                    end
                end
                running: begin
                    if (lockout || overTempCmp) begin
                        state_reg <= lockoutHeld;
                    end
                end
                default: state_reg <= lockoutHeld;
            endcase
        end
    end

    // Remember which supply was last under lockout so the exit marks it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lastLogic_reg <= 1'b1;
        end else if (clkEn && lockout) begin
            lastLogic_reg <= logicLockoutCmp;
        end
    end

    // A thermal-only hold must not report a supply lockout on exit.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lockSeen_reg <= 1'b1;
        end else if (clkEn) begin
            if (lockout) begin
                lockSeen_reg <= 1'b1;
            end else if (state_reg == running) begin
                lockSeen_reg <= 1'b0;
            end
        end
    end

    assign portsForcedOff = (state_reg != running);
    assign deviceInReset  = (state_reg != running);

    // ======================================================================
    // Access decode
    // Clear strobes come straight from the request; clkEn gates their effect.
    logic clrAll;
    logic rdPower;
    logic rdDetect;
    logic rdFault;
    logic rdStartup;
    logic rdSupply;
    assign clrAll = regWrite && regAddr == `ADDR_GLOBAL_CMD
                    && regWrData[`BIT_CLEAR_ALL];
    assign rdPower   = regRead && regAddr == `ADDR_POWER_CLR;
    assign rdDetect  = regRead && regAddr == `ADDR_DETECT_CLR;
    assign rdFault   = regRead && regAddr == `ADDR_FAULT_CLR;
    assign rdStartup = regRead && regAddr == `ADDR_STARTUP_CLR;
    assign rdSupply  = regRead && regAddr == `ADDR_SUPPLY_CLR;

    // ======================================================================
    // Control registers
    // The mask clears on every internal reset, so a lockout silences the pin.
    byte_t enable_reg;
    logic  globalEn_reg;
    always_ff @(posedge clk_sys) begin
        if (holdReset) begin
            enable_reg   <= `RESET_ENABLE;
            globalEn_reg <= 1'b0;
        end else if (clkEn && regWrite) begin
            if (regAddr == `ADDR_ENABLE) begin
                enable_reg <= regWrData;
            end
            if (regAddr == `ADDR_CONFIG) begin
                globalEn_reg <= regWrData[`BIT_GLOBAL_INT_EN];
            end
        end
    end

    // ======================================================================
    // Event registers; a new event is ORed after the clear so it wins.
    byte_t power_reg;
    byte_t detect_reg;
    byte_t fault_reg;
    byte_t startup_reg;
    byte_t supply_reg;
    byte_t pwrPrev_reg;
    byte_t pwrNow;
    byte_t supplyEvt;
    assign pwrNow = {power_good, power_on_status};
    always_comb begin
        supplyEvt                     = `RESET_BYTE;
        supplyEvt[`BIT_LOGIC_OVER]    = logicOverCmp;
        supplyEvt[`BIT_NEG_OVER]      = negOverCmp;
        supplyEvt[`BIT_LOGIC_UNDER]   = logicUnderCmp;
        supplyEvt[`BIT_NEG_UNDER]     = negUnderCmp;
        supplyEvt[`BIT_OSC_WEAK]      = oscWeakCmp;
        if (resumed) begin
            supplyEvt[`BIT_THERMAL]   = 1'b1;
        end
        if (resumed && lockSeen_reg) begin
            supplyEvt[`BIT_LOGIC_LOCKOUT] = lastLogic_reg;
            supplyEvt[`BIT_LOGIC_UNDER]   = logicUnderCmp | lastLogic_reg;
            supplyEvt[`BIT_NEG_LOCKOUT]   = !lastLogic_reg;
            supplyEvt[`BIT_NEG_UNDER]     = negUnderCmp | !lastLogic_reg;
        end
    end

    // Levels reset to zero, so a port powered at release reports a change.
    always_ff @(posedge clk_sys) begin
        if (holdReset) begin
            pwrPrev_reg <= `RESET_BYTE;
        end else if (clkEn) begin
            pwrPrev_reg <= pwrNow;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (holdReset) begin
            power_reg   <= `RESET_BYTE;
            detect_reg  <= `RESET_BYTE;
            fault_reg   <= `RESET_BYTE;
            startup_reg <= `RESET_BYTE;
        end else if (clkEn) begin
            power_reg <= ((rdPower || clrAll) ? `RESET_BYTE : power_reg)
                         | (pwrNow ^ pwrPrev_reg);
            detect_reg <= ((rdDetect || clrAll) ? `RESET_BYTE : detect_reg)
                          | {classDoneEvt, detectDoneEvt};
            fault_reg <= ((rdFault || clrAll) ? `RESET_BYTE : fault_reg)
                         | {loadRemovedEvt, overcurrentEvt};
            startup_reg <= ((rdStartup || clrAll) ? `RESET_BYTE
                            : startup_reg)
                           | {classOvercurrentEvt, startupFailedEvt};
        end
    end

    // Supply flags survive the lockout so the exit marks can be recorded.
    // Only rst clears them while the device is held.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            supply_reg <= `RESET_BYTE;
        end else if (clkEn && !holdReset) begin
            supply_reg <= ((rdSupply || clrAll) ? `RESET_BYTE : supply_reg)
                          | supplyEvt;
        end
    end

    // ======================================================================
    // Port results
    // A load pulse replaces both codes at once; no half-updated pair is seen.
    logic [6:0] status_reg [PORTS];
    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < PORTS; p++) begin
            if (holdReset) begin
                status_reg[p] <= 7'h00;
            end else if (clkEn && resultLoad[p]) begin
                status_reg[p] <= {classResult[p*3 +: 3], 1'b0,
                                  detectResult[p*3 +: 3]};
            end
        end
    end

    // ======================================================================
    // Summary and interrupt
    byte_t summary;
    logic  oscGate;
    // Only the oscillator flag is gated: it matters only while AC sensing runs.
    assign oscGate = |ac_disconnect_enable;
    always_comb begin
        summary[7] = |{supply_reg[7:2], supply_reg[0],
                       supply_reg[`BIT_OSC_WEAK] & oscGate};
        summary[6] = |startup_reg;
        summary[5] = |fault_reg[3:0];
        summary[4] = |detect_reg[7:4];
        summary[3] = |detect_reg[3:0];
        summary[2] = |fault_reg[7:4];
        summary[1] = |power_reg[7:4];
        summary[0] = |power_reg[3:0];
    end

    // The pin is registered so a decode glitch can never pulse it.
    always_ff @(posedge clk_sys) begin
        if (holdReset) begin
            intr_n <= 1'b1;
        end else if (clkEn) begin
            intr_n <= !(globalEn_reg && |(summary & enable_reg));
        end
    end

    // ======================================================================
    // Read data, registered on the read strobe.
    // Unmapped addresses read as zero.
    byte_t rdMux;
    always_comb begin
        rdMux = `RESET_BYTE;
        case (regAddr)
            `ADDR_SUMMARY:                     rdMux = summary;
            `ADDR_ENABLE:                      rdMux = enable_reg;
            `ADDR_POWER_VIEW, `ADDR_POWER_CLR: rdMux = power_reg;
            `ADDR_DETECT_VIEW, `ADDR_DETECT_CLR: rdMux = detect_reg;
            `ADDR_FAULT_VIEW, `ADDR_FAULT_CLR: rdMux = fault_reg;
            `ADDR_STARTUP_VIEW, `ADDR_STARTUP_CLR: rdMux = startup_reg;
            `ADDR_SUPPLY_VIEW, `ADDR_SUPPLY_CLR: rdMux = supply_reg;
            `ADDR_POWER_STATUS:                rdMux = pwrNow;
            `ADDR_CONFIG:     rdMux = {globalEn_reg, 7'h00};
            default: begin
                if (regAddr >= `ADDR_PORT1_STATUS
                    && regAddr <= `ADDR_PORT4_STATUS)
                    rdMux = {1'b0, status_reg[regAddr[1:0]]};
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= `RESET_BYTE;
        end else if (clkEn && regRead) begin
            regRdData <= rdMux;
        end
    end
endmodule

// [src/pse_event_cfg.svh]
`ifndef PSE_EVENT_CFG_SVH
`define PSE_EVENT_CFG_SVH

// ==========================================================================
// Register map
`define ADDR_SUMMARY          8'h00
`define ADDR_ENABLE           8'h01
`define ADDR_POWER_VIEW       8'h02
`define ADDR_POWER_CLR        8'h03
`define ADDR_DETECT_VIEW      8'h04
`define ADDR_DETECT_CLR       8'h05
`define ADDR_FAULT_VIEW       8'h06
`define ADDR_FAULT_CLR        8'h07
`define ADDR_STARTUP_VIEW     8'h08
`define ADDR_STARTUP_CLR      8'h09
`define ADDR_SUPPLY_VIEW      8'h0A
`define ADDR_SUPPLY_CLR       8'h0B
`define ADDR_PORT1_STATUS     8'h0C
`define ADDR_PORT4_STATUS     8'h0F
`define ADDR_POWER_STATUS     8'h10
`define ADDR_CONFIG           8'h17
`define ADDR_GLOBAL_CMD       8'h1A

// ==========================================================================
// Field positions and reset values
`define BIT_GLOBAL_INT_EN     7
`define BIT_CLEAR_ALL         7
`define BIT_THERMAL           7
`define BIT_LOGIC_OVER        6
`define BIT_LOGIC_UNDER       5
`define BIT_NEG_LOCKOUT       4
`define BIT_NEG_OVER          3
`define BIT_NEG_UNDER         2
`define BIT_OSC_WEAK          1
`define BIT_LOGIC_LOCKOUT     0
`define RESET_BYTE            8'h00
`define RESET_ENABLE          8'h00

`endif

// [src/pse_event_pkg.sv]
package pse_event_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        unknown_code,
        positive_source_code,
        large_capacitance_code,
        low_resistance_code,
        signature_valid_code,
        high_resistance_code,
        open_port_code,
        negative_source_code
    } detect_result_code_t;
    typedef enum {
        lockoutHeld,
        running
    } life_state_t;
endpackage

// [dv/pse_event_chk.sv]
`timescale 1ns/1ps
`include "pse_event_cfg.svh"
// ==========
// Port checker
module pse_event_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       clkEn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // Events and monitors
    input wire logic [3:0] overcurrentEvt,
    input wire logic [3:0] loadRemovedEvt,
    input wire logic       logicLockoutCmp,
    input wire logic       negLockoutCmp,
    input wire logic       overTempCmp,
    // Outputs
    input wire logic       intr_n,
    input wire logic       portsForcedOff
);
    wire rdTake = regRead && clkEn;
    wire wrTake = regWrite && clkEn;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ports_off: assert property ((logicLockoutCmp || negLockoutCmp) &&
        clkEn |=> portsForcedOff) else $error("ports not off");
    a_lock_exit: assert property (clkEn && !logicLockoutCmp &&
        !negLockoutCmp && !overTempCmp |=> !portsForcedOff)
        else $error("held");
    a_mask_off: assert property (wrTake && regAddr == `ADDR_ENABLE &&
        regWrData == 8'h00 ##1 !wrTake |=> intr_n) else $error("masked irq");
    a_global_off: assert property (wrTake && regAddr == `ADDR_CONFIG &&
        !regWrData[7] ##1 !wrTake |=> intr_n) else $error("gated irq");
    a_status_rsvd: assert property (rdTake &&
        regAddr >= `ADDR_PORT1_STATUS && regAddr <= `ADDR_PORT4_STATUS
        |=> !regRdData[7] && !regRdData[3]) else $error("reserved set");
    a_clear_empty: assert property (rdTake &&
        regAddr == `ADDR_FAULT_CLR &&
        overcurrentEvt == 4'h0 && loadRemovedEvt == 4'h0 ##1 rdTake &&
        regAddr == `ADDR_FAULT_VIEW |=> regRdData == 8'h00)
        else $error("not cleared");
    a_event_kept: assert property (rdTake &&
        regAddr == `ADDR_FAULT_CLR && overcurrentEvt[3] ##1 rdTake &&
        regAddr == `ADDR_FAULT_VIEW |=> regRdData[3]) else $error("lost");
    a_view_keeps: assert property (rdTake &&
        regAddr == `ADDR_STARTUP_VIEW ##1 rdTake &&
        regAddr == `ADDR_STARTUP_VIEW |=> (regRdData & $past(regRdData))
        == $past(regRdData)) else $error("view cleared");
endmodule
bind pse_event_interrupt_regs pse_event_chk u_chk (.clk_sys(clk_sys),
    .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .overcurrentEvt(overcurrentEvt), .loadRemovedEvt(loadRemovedEvt),
    .logicLockoutCmp(logicLockoutCmp), .negLockoutCmp(negLockoutCmp),
    .overTempCmp(overTempCmp), .intr_n(intr_n),
    .portsForcedOff(portsForcedOff));

// [dv/pse_host_model.sv]
`timescale 1ns/1ps
// ==========
// Host side of the register port
module pse_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic [7:0]      regAddr = 8'h00,
    output logic            regWrite = 1'b0,
    output logic            regRead = 1'b0,
    output logic [7:0]      regWrData = 8'h00,
    input  wire logic [7:0] regRdData
);
    // Launched off a falling edge and held over the taking edge, so the
    // answer is settled by the next falling edge.
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        regWrite = w;
        regRead = !w;
        regAddr = a;
        regWrData = d;
        @(negedge clk_sys);
        q = regRdData;
    endtask
    // Released data is inverted so a stale byte is never mistaken for data.
    task automatic idle();
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = ~regWrData;
        @(negedge clk_sys);
    endtask
endmodule

// [dv/test_pse_event_interrupt_regs.sv]
`timescale 1ns/1ps
`include "pse_event_cfg.svh"
module test_pse_event_interrupt_regs;
    import pse_event_pkg::*;
    // ==========
    // Stimulus and wiring
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  ev = 8'h00;
    logic [3:0]  pg = 4'h0, pe = 4'h0, acd = 4'h0, rl = 4'h0;
    logic [11:0] cls = 12'h000, det = 12'h000;
    logic        lkN = 1'b0, lkL = 1'b0, ot = 1'b0, osc = 1'b0;
    logic [7:0]  regAddr, regWrData, regRdData, q;
    logic        regWrite, regRead, intr_n, offSig, inRst;
    logic [7:0]  ca [8] = '{8'h03, 8'h03, 8'h07, 8'h05, 8'h05, 8'h07,
                           8'h09, 8'h0B};
    logic [7:0]  ex [8] = '{8'h08, 8'h80, 8'h80, 8'h08, 8'h80, 8'h08,
                           8'h88, 8'h6C};
    int          n_mismatch = 0, checked = 0;
    always #20 clk_sys = ~clk_sys;
    pse_host_model host (.clk_sys(clk_sys), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
        .regRdData(regRdData));
    pse_event_interrupt_regs DUT (.clk_sys(clk_sys), .rst(rst),
        .clkEn(1'b1), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
        .power_good(pg), .power_on_status(pe), .classDoneEvt({ev[4], 3'h0}),
        .detectDoneEvt({ev[3], 3'h0}), .loadRemovedEvt({ev[2], 3'h0}),
        .overcurrentEvt({ev[5], 3'h0}), .classOvercurrentEvt({ev[6], 3'h0}),
        .startupFailedEvt({ev[6], 3'h0}), .classResult(cls),
        .detectResult(det), .resultLoad(rl), .ac_disconnect_enable(acd),
        .logicOverCmp(ev[7]), .logicUnderCmp(ev[7]), .negOverCmp(ev[7]),
        .negUnderCmp(ev[7]), .logicLockoutCmp(lkL), .negLockoutCmp(lkN),
        .oscWeakCmp(osc), .overTempCmp(ot), .intr_n(intr_n),
        .portsForcedOff(offSig), .deviceInReset(inRst));
    task automatic chk(string nm, logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(logic [7:0] a, exp);
        host.xfer(1'b0, a, 8'h00, q);
        chk($sformatf("reg%h", a), q, exp);
    endtask
    task automatic wr(logic [7:0] a, d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic gap(int n);
        repeat (n) host.idle();
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end
    initial begin
        gap(6);
        rst = 1'b0;
        gap(3);
        rd(`ADDR_SUPPLY_VIEW, 8'hA1);
        rd(`ADDR_SUPPLY_CLR, 8'hA1);
        rd(`ADDR_STARTUP_VIEW, 8'h00);
        rd(`ADDR_ENABLE, 8'h00);
        for (int i = 7; i >= 0; i--) begin
            ev = 8'h01 << i;
            pg = pg ^ {i == 1, 3'h0};
            pe = pe ^ {i == 0, 3'h0};
            gap(1);
            ev = 8'h00;
            wr(`ADDR_ENABLE, 8'h01 << i);
            wr(`ADDR_CONFIG, 8'h00);
            gap(2);
            chk("intr_n", {7'h00, intr_n}, 8'h01);
            wr(`ADDR_CONFIG, 8'h80);
            gap(2);
            chk("intr_n", {7'h00, intr_n}, 8'h00);
            rd(`ADDR_SUMMARY, 8'h01 << i);
            rd(ca[i] - 8'h01, ex[i]);
            rd(ca[i] - 8'h01, ex[i]);
            rd(ca[i], ex[i]);
            rd(ca[i] - 8'h01, 8'h00);
        end
        pg = 4'h0;
        gap(1);
        rd(`ADDR_POWER_CLR, 8'h80);
        wr(`ADDR_ENABLE, 8'h80);
        osc = 1'b1;
        gap(1);
        osc = 1'b0;
        gap(2);
        chk("intr_n", {7'h00, intr_n}, 8'h01);
        acd = 4'h1;
        gap(2);
        chk("intr_n", {7'h00, intr_n}, 8'h00);
        wr(`ADDR_ENABLE, 8'h00);
        gap(2);
        chk("intr_n", {7'h00, intr_n}, 8'h01);
        rd(`ADDR_SUPPLY_CLR, 8'h02);
        ev = 8'h20;
        rd(`ADDR_FAULT_CLR, 8'h00);
        ev = 8'h00;
        rd(`ADDR_FAULT_VIEW, 8'h08);
        ev = 8'hFF;
        gap(1);
        ev = 8'h00;
        wr(`ADDR_GLOBAL_CMD, 8'h80);
        gap(1);
        rd(`ADDR_SUMMARY, 8'h00);
        for (int c = 0; c < 8; c++) begin
            det = {4{detect_result_code_t'(c)}};
            cls = {4{3'(7 - c)}};
            rl = 4'hF;
            gap(1);
            rl = 4'h0;
            rd(`ADDR_PORT4_STATUS, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
        end
        wr(`ADDR_PORT1_STATUS, 8'hFF);
        rd(`ADDR_PORT1_STATUS, 8'h07);
        lkN = 1'b1;
        gap(2);
        chk("offSig", {7'h00, offSig}, 8'h01);
        lkN = 1'b0;
        gap(2);
        chk("offSig", {7'h00, offSig}, 8'h00);
        rd(`ADDR_SUPPLY_CLR, 8'h94);
        lkL = 1'b1;
        gap(2);
        chk("offSig", {7'h00, offSig}, 8'h01);
        lkL = 1'b0;
        gap(2);
        chk("offSig", {7'h00, offSig}, 8'h00);
        rd(`ADDR_SUPPLY_CLR, 8'hA1);
        ot = 1'b1;
        gap(2);
        chk("inRst", {7'h00, inRst}, 8'h01);
        ot = 1'b0;
        gap(2);
        host.xfer(1'b0, `ADDR_SUPPLY_CLR, 8'h00, q);
        chk("thermal", q, 8'h80);
        finish_test();
    end
endmodule
